// File: asc_pkg.sv
// Constants shared by the asynchronous SRAM host controller
package asc_pkg;
    // ------------------------------------------------------------
    // Clock and pin timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_AA_NS = 55;   // Address access time, longest
    localparam int T_RC_NS = 55;   // Read cycle time, least
    localparam int T_WP_NS = 45;   // Write pulse width, least
    localparam int T_WHZ_NS = 20;  // Write to output high-Z, longest wait
    localparam int T_DW_NS = 25;   // Data to write overlap, least
    localparam int T_OHZ_NS = 20;  // Output disable to high-Z, longest wait
    localparam int T_WC_NS = 55;   // Write cycle time, least
    // Waits on the device round up so the host never acts early
    localparam int AA_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RC_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WHZ_CYC = (T_WHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DW_CYC = (T_DW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OHZ_CYC = (T_OHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WC_CYC = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // Derived sequence counts
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 2;
    localparam int READ_WAIT = (AA_CYC > RC_CYC ? AA_CYC : RC_CYC) + SYNC_STAGES;
    localparam int WR_PULSE = (WP_CYC > WHZ_CYC + DW_CYC) ? WP_CYC : WHZ_CYC + DW_CYC;
    localparam int WR_SPAN = WR_PULSE + 1 + OHZ_CYC;
    localparam int CNT_W = 5;
    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int WORD_COUNT = 1048576;
    localparam int BYTE_COUNT = 2097152;
    localparam int PIN_ADDR_W = 20;
    localparam int USER_ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int ADDR_PIN = 15;   // Data pin that carries the byte address bit
    localparam logic WORD_MODE_DEF = 1'b1;
    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_WRITE = 4'h4,
        ST_RECOVER = 4'h8
    } asc_state_t;
endpackage

// File: asc_sync.sv
// Two-stage synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module asc_sync #(
    parameter int WIDTH = 16
) (
    input wire logic clock,               // System clock
    input wire logic reset_n,             // Asynchronous reset, active low
    input wire logic clock_enable,        // Freezes both stages when low
    input wire logic [WIDTH-1:0] pin_in,  // Asynchronous pin levels
    output logic [WIDTH-1:0] sync_out     // Levels in the clock domain
);
    logic [WIDTH-1:0] stage1;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (WIDTH < 1) begin : g_chk
        $error("asc_sync: WIDTH must be at least 1");
    end

    // First stage feeds only the second, to let metastability settle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            sync_out <= '0;
        end else if (clock_enable) begin
            stage1 <= pin_in;
            sync_out <= stage1;
        end
    end
endmodule

// File: asc_host.sv
// Host controller driving an asynchronous word/byte SRAM through its pins
// Behaviour
// R1 - Array is 1M words or 2M bytes
// R2 - Host holds width strap fixed, high for words
// R3 - Byte mode: lanes low, pins 8-14 unused
// R4 - Byte mode: pin 15 carries lowest address
// R5 - Low lane select gates pins 0-7
// R6 - High lane select gates pins 8-15
// R7 - Write needs both selects, strobe, lane low
// R8 - Read drives data when output enable low
// R9 - Selects after strobe fall keep outputs off
// R10 - Hold strobe until device drivers turn off
// R11 - Never drive pins while device drives
// R12 - Address valid before selects assert; code changes address and selects on the same edge
// R13 - Device corrects single bit errors per byte
// R14 - Pins float when deselected or idle
`timescale 1ns/1ps
module asc_host #(
    parameter logic WORD_MODE = asc_pkg::WORD_MODE_DEF
) (
    input wire logic clock,                                   // 200 MHz system clock
    input wire logic reset_n,                                 // Asynchronous reset, active low
    input wire logic clock_enable,                            // Freezes all state when low
    input wire logic req_valid,                               // Access request
    output logic req_ready,                                   // Controller can take a request
    input wire logic req_write,                               // 1 write, 0 read
    input wire logic [asc_pkg::USER_ADDR_W-1:0] req_addr,     // Word or byte address
    input wire logic [asc_pkg::DATA_W-1:0] req_wdata,         // Write data
    input wire logic [1:0] req_lane_en,                       // Lane enables, word mode only
    output logic resp_valid,                                  // Read data pulse
    output logic [asc_pkg::DATA_W-1:0] resp_rdata,            // Read data
    output logic width_strap,                                 // 1 word, 0 byte organisation
    output logic [asc_pkg::PIN_ADDR_W-1:0] word_address,      // Address pins
    output logic chip_select_n,                               // Chip select, active low
    output logic chip_select_high_active,                     // Chip select, active high
    output logic write_strobe_n,                              // Write strobe, active low
    output logic output_enable_n,                             // Output enable, active low
    output logic lower_lane_select_n,                         // Lane select pins 0-7
    output logic upper_lane_select_n,                         // Lane select pins 8-15
    input wire logic [asc_pkg::DATA_W-1:0] shared_data_in,    // Data pin levels
    output logic [asc_pkg::DATA_W-1:0] shared_data_out,       // Data pin drive values
    output logic [asc_pkg::DATA_W-1:0] shared_data_oe         // Data pin drive enables
);
    asc_pkg::asc_state_t state;
    logic [asc_pkg::CNT_W-1:0] cnt;
    logic [asc_pkg::DATA_W-1:0] data_sync;
    logic [asc_pkg::DATA_W-1:0] wdata_hold;
    logic [asc_pkg::DATA_W-1:0] write_mask;
    logic [asc_pkg::DATA_W-1:0] next_addr_drive;
    logic take;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (asc_pkg::READ_WAIT >= 32 || asc_pkg::WR_SPAN >= 32) begin : g_chk_cnt
        $error("asc_host: counter too narrow for timing");
    end
    if (asc_pkg::WORD_COUNT * 2 != asc_pkg::BYTE_COUNT) begin : g_chk_geo
        $error("asc_host: inconsistent array geometry");
    end

    // Read data passes two flops before anything looks at it
    asc_sync #(
        .WIDTH(asc_pkg::DATA_W)
    ) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .clock_enable(clock_enable),
        .pin_in(shared_data_in),
        .sync_out(data_sync)
    );

    // ------------------------------------------------------------
    // Request acceptance
    // ------------------------------------------------------------
    assign take = req_valid && req_ready && (state == asc_pkg::ST_IDLE);
    // Byte mode writes only the low lane; pins 8-14 stay released
    assign write_mask = WORD_MODE ? {{8{req_lane_en[1]}}, {8{req_lane_en[0]}}} : 16'h00FF; // [R3] [R5] [R6]
    // Byte mode: the extra address bit rides on pin 15 for the whole access
    assign next_addr_drive = WORD_MODE ? 16'h0000 : {req_addr[0], 15'h0000}; // [R4]

    // Sequencer state and cycle counter
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= asc_pkg::ST_IDLE;
            cnt <= '0;
        end else if (clock_enable) begin
            case (state)
                asc_pkg::ST_IDLE: begin
                    cnt <= '0;
                    if (take) begin
                        state <= req_write ? asc_pkg::ST_WRITE : asc_pkg::ST_READ;
                    end
                end
                asc_pkg::ST_READ: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == asc_pkg::CNT_W'(asc_pkg::READ_WAIT - 1)) begin
                        state <= asc_pkg::ST_RECOVER;
                        cnt <= '0;
                    end
                end
                asc_pkg::ST_WRITE: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == asc_pkg::CNT_W'(asc_pkg::WR_PULSE)) begin
                        state <= asc_pkg::ST_RECOVER;
                        cnt <= '0;
                    end
                end
                asc_pkg::ST_RECOVER: begin
                    // Gives device drivers time to release before the next access
                    cnt <= cnt + 1'b1;
                    if (cnt == asc_pkg::CNT_W'(asc_pkg::OHZ_CYC - 1)) begin // [R11]
                        state <= asc_pkg::ST_IDLE;
                        cnt <= '0;
                    end
                end
                default: begin
                    state <= asc_pkg::ST_IDLE;
                    cnt <= '0;
                end
            endcase
        end
    end

    // Ready returns only once the bus has settled
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            req_ready <= 1'b1;
        end else if (clock_enable) begin
            if (take) begin
                req_ready <= 1'b0;
            end else if (state == asc_pkg::ST_RECOVER && cnt == asc_pkg::CNT_W'(asc_pkg::OHZ_CYC - 1)) begin
                req_ready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Strap, address and select pins
    // ------------------------------------------------------------
    // Strap is a constant of the build, never switched at run time
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            width_strap <= WORD_MODE; // [R2] [R1]
        end else if (clock_enable) begin
            width_strap <= WORD_MODE; // [R2]
        end
    end

    // Address and selects change together with the request, address never later
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            word_address <= '0;
            chip_select_n <= 1'b1;
            chip_select_high_active <= 1'b0;
            lower_lane_select_n <= WORD_MODE;
            upper_lane_select_n <= WORD_MODE;
        end else if (clock_enable) begin
            if (take) begin
                word_address <= WORD_MODE ? req_addr[19:0] : req_addr[20:1]; // [R12] [R1]
                chip_select_n <= 1'b0;
                chip_select_high_active <= 1'b1;
                lower_lane_select_n <= WORD_MODE ? !req_lane_en[0] : 1'b0; // [R3] [R5]
                upper_lane_select_n <= WORD_MODE ? !req_lane_en[1] : 1'b0; // [R3] [R6]
            end else if ((state == asc_pkg::ST_READ && cnt == asc_pkg::CNT_W'(asc_pkg::READ_WAIT - 1))
                         || (state == asc_pkg::ST_WRITE && cnt == asc_pkg::CNT_W'(asc_pkg::WR_PULSE))) begin
                // Deselect parks the device pins in high impedance
                chip_select_n <= 1'b1; // [R14]
                chip_select_high_active <= 1'b0;
                lower_lane_select_n <= WORD_MODE;
                upper_lane_select_n <= WORD_MODE;
            end
        end
    end

    // ------------------------------------------------------------
    // Strobes
    // ------------------------------------------------------------
    // Output enable stays high in writes, so device drivers never fight ours
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            output_enable_n <= 1'b1;
            write_strobe_n <= 1'b1;
        end else if (clock_enable) begin
            if (take) begin
                output_enable_n <= req_write; // [R8]
                write_strobe_n <= !req_write; // [R7] [R9]
            end else if (state == asc_pkg::ST_READ && cnt == asc_pkg::CNT_W'(asc_pkg::READ_WAIT - 1)) begin
                output_enable_n <= 1'b1;
            end else if (state == asc_pkg::ST_WRITE && cnt == asc_pkg::CNT_W'(asc_pkg::WR_PULSE - 1)) begin
                write_strobe_n <= 1'b1; // [R7]
            end
        end
    end

    // ------------------------------------------------------------
    // Data pin drive
    // ------------------------------------------------------------
    // Write data waits out the device's turn-off time after the strobe falls
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            shared_data_out <= '0;
            shared_data_oe <= '0;
            wdata_hold <= '0;
        end else if (clock_enable) begin
            if (take) begin
                wdata_hold <= req_wdata & write_mask;
                shared_data_out <= next_addr_drive; // [R4]
                // Pin 15 is driven in byte mode whatever the address bit, a floating address is never seen
                shared_data_oe <= {!WORD_MODE, 15'h0000}; // [R4]
            end else if (state == asc_pkg::ST_WRITE && cnt == asc_pkg::CNT_W'(asc_pkg::WHZ_CYC - 1)) begin
                shared_data_out <= wdata_hold | shared_data_out; // [R10]
                // Every data pin of the organisation is driven, zero bits included, so none floats
                shared_data_oe <= shared_data_oe | (WORD_MODE ? 16'hFFFF : 16'h00FF); // [R10] [R3]
            end else if (state == asc_pkg::ST_RECOVER) begin
                shared_data_out <= '0; // [R11]
                shared_data_oe <= '0;
            end
        end
    end

    // Read data is captured after access time plus synchroniser delay
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            resp_valid <= 1'b0;
            resp_rdata <= '0;
        end else if (clock_enable) begin
            resp_valid <= 1'b0;
            if (state == asc_pkg::ST_READ && cnt == asc_pkg::CNT_W'(asc_pkg::READ_WAIT - 1)) begin
                resp_valid <= 1'b1; // [R13]
                resp_rdata <= WORD_MODE ? data_sync : {8'h00, data_sync[7:0]}; // [R3]
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    strap_stable_a: assert property (##1 $stable(width_strap) && width_strap == WORD_MODE) // [R2]
        else $error("width strap changed");
    byte_lanes_low_a: assert property (!WORD_MODE && !chip_select_n |->
        !lower_lane_select_n && !upper_lane_select_n && shared_data_oe[14:8] == 7'h00) // [R3]
        else $error("byte mode lane or upper pin misuse");
    write_drive_wait_a: assert property ($fell(write_strobe_n) |->
        (shared_data_oe[14:0] == 15'h0000) [*4]) // [R10]
        else $error("write data driven before device release");
    no_contention_a: assert property (!output_enable_n |->
        shared_data_oe[14:0] == 15'h0000 && (!WORD_MODE || !shared_data_oe[15])) // [R11]
        else $error("host drives pins during read");
    addr_stable_a: assert property (!chip_select_n && $past(!chip_select_n) |-> $stable(word_address)) // [R12]
        else $error("address moved while selected");

    read_seen_c: cover property (take && !req_write ##[1:40] resp_valid);
    write_seen_c: cover property ($fell(write_strobe_n) ##[1:20] $rose(write_strobe_n));
    rd_then_wr_c: cover property (resp_valid ##[1:20] $fell(write_strobe_n));
endmodule

// File: asc_sram_model.sv
// Behavioural model of the word/byte SRAM seen from the host pins
`timescale 1ns/1ps
module asc_sram_model #(
    parameter int FAST_LAT = 1,
    parameter int SLOW_LAT = 9
) (
    input wire logic clock,                    // Bench clock, host pins move on its edges
    input wire logic slow,                     // High: answer late, still within access time
    input wire logic width_strap,              // 1 word, 0 byte organisation
    input wire logic [19:0] word_address,      // Address pins
    input wire logic chip_select_n,            // Chip select, active low
    input wire logic chip_select_high_active,  // Chip select, active high
    input wire logic write_strobe_n,           // Write strobe, active low
    input wire logic output_enable_n,          // Output enable, active low
    input wire logic lower_lane_select_n,      // Lane select pins 0-7
    input wire logic upper_lane_select_n,      // Lane select pins 8-15
    input wire logic [15:0] pins,              // Resolved data pin levels
    output logic [15:0] dev_out,               // Device drive values
    output logic [15:0] dev_oe                 // Device drive enables
);
    // ------------------------------------------------------------
    // Byte array, one entry per stored byte
    // ------------------------------------------------------------
    logic [7:0] mem [int];
    logic [7:0] b;
    int cnt;
    logic sel;
    logic rd;
    logic [1:0] lane;
    assign sel = !chip_select_n && chip_select_high_active;
    assign rd = sel && write_strobe_n && !output_enable_n;
    assign lane = width_strap ? ~{upper_lane_select_n, lower_lane_select_n} : 2'b01;
    // Byte index; in byte mode pin 15 is the lowest address bit
    function automatic int byte_at(input int l);
        return width_strap ? int'({word_address, l[0]}) : int'({word_address, pins[15]});
    endfunction
    // Store, count read time, drive lanes; wrong data until latency runs out
    always @(posedge clock) begin
        for (int l = 0; l < 2; l++) begin
            if (sel && !write_strobe_n && lane[l]) begin
                mem[byte_at(l)] = pins[8*l +: 8];
            end
        end
        cnt = rd ? cnt + 1 : 0;
        dev_oe <= 16'h0000;
        for (int l = 0; l < 2; l++) begin
            if (rd && lane[l]) begin
                b = mem.exists(byte_at(l)) ? mem[byte_at(l)] : 8'h00;
                dev_oe[8*l +: 8] <= 8'hFF;
                dev_out[8*l +: 8] <= (cnt >= (slow ? SLOW_LAT : FAST_LAT)) ? b : ~b ^ cnt[7:0];
            end
        end
    end
endmodule

// File: async_sram_word_byte_port_test.sv
// Self-checking bench for the SRAM host controller in word and byte organisation
`timescale 1ns/1ps
module async_sram_word_byte_port_test;
    logic clock, reset_n, clock_enable, req_valid, req_write, slow, req_ready, resp_valid, width_strap;
    logic chip_select_n, chip_select_high_active, write_strobe_n, output_enable_n;
    logic lower_lane_select_n, upper_lane_select_n;
    logic [20:0] req_addr;
    logic [19:0] word_address, cur_addr;
    logic [15:0] req_wdata, resp_rdata, host_out, host_oe, dev_out, dev_oe, pins;
    logic [15:0] flip = 16'h5A3C;
    logic [1:0] req_lane_en, cur_lane;
    logic [15:0] ref_mem [int];
    logic [31:0] exp_q [$];
    logic [31:0] e;
    logic [19:0] tab [4] = '{20'h00000, 20'hFFFFF, 20'h00001, 20'h80000};
    int n_fail, samples_checked, seed, rd_cnt, i;
    // Second controller built for the byte organisation, fed the same requests in lockstep
    logic rdy_b, rv_b, strap_b, cs_n_b, cs_h_b, we_n_b, oe_n_b, lb_n_b, ub_n_b;
    logic [19:0] word_address_b;
    logic [15:0] rdata_b, host_out_b, host_oe_b, dev_out_b, dev_oe_b, pins_b;
    logic [20:0] cur_b;
    logic [7:0] ref_b [int];
    logic [7:0] exp_b [$];

    // Released pins wander every cycle so a stale value never passes
    always @(posedge clock) flip <= ~flip;
    assign pins = (host_oe & host_out) | (dev_oe & dev_out) | (~host_oe & ~dev_oe & flip);

    asc_host u_dut (.clock(clock), .reset_n(reset_n), .clock_enable(clock_enable), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_lane_en(req_lane_en), .resp_valid(resp_valid), .resp_rdata(resp_rdata), .width_strap(width_strap),
        .word_address(word_address), .chip_select_n(chip_select_n),
        .chip_select_high_active(chip_select_high_active), .write_strobe_n(write_strobe_n),
        .output_enable_n(output_enable_n), .lower_lane_select_n(lower_lane_select_n),
        .upper_lane_select_n(upper_lane_select_n), .shared_data_in(pins), .shared_data_out(host_out),
        .shared_data_oe(host_oe));
    asc_sram_model u_mem (.clock(clock), .slow(slow), .width_strap(width_strap), .word_address(word_address),
        .chip_select_n(chip_select_n), .chip_select_high_active(chip_select_high_active),
        .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
        .lower_lane_select_n(lower_lane_select_n), .upper_lane_select_n(upper_lane_select_n),
        .pins(pins), .dev_out(dev_out), .dev_oe(dev_oe));
    assign pins_b = (host_oe_b & host_out_b) | (dev_oe_b & dev_out_b) | (~host_oe_b & ~dev_oe_b & flip);
    asc_host #(.WORD_MODE(1'b0)) u_dut_b (.clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
        .req_valid(req_valid), .req_ready(rdy_b), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_lane_en(req_lane_en), .resp_valid(rv_b), .resp_rdata(rdata_b),
        .width_strap(strap_b), .word_address(word_address_b), .chip_select_n(cs_n_b),
        .chip_select_high_active(cs_h_b), .write_strobe_n(we_n_b), .output_enable_n(oe_n_b),
        .lower_lane_select_n(lb_n_b), .upper_lane_select_n(ub_n_b), .shared_data_in(pins_b),
        .shared_data_out(host_out_b), .shared_data_oe(host_oe_b));
    asc_sram_model u_mem_b (.clock(clock), .slow(slow), .width_strap(strap_b), .word_address(word_address_b),
        .chip_select_n(cs_n_b), .chip_select_high_active(cs_h_b), .write_strobe_n(we_n_b),
        .output_enable_n(oe_n_b), .lower_lane_select_n(lb_n_b), .upper_lane_select_n(ub_n_b),
        .pins(pins_b), .dev_out(dev_out_b), .dev_oe(dev_oe_b));

    // ------------------------------------------------------------
    // Shared checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // One request from a falling edge; waits for ready with the clock enable wandering
    task automatic do_op(input bit wr, input logic [20:0] a, input logic [15:0] d, input logic [1:0] ln);
        int k;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_lane_en = ln;
        for (k = 0; k < 300; k++) begin
            clock_enable = ($random(seed) & 3) != 0;
            if (req_ready === 1'b1 && clock_enable) break;
            @(negedge clock);
        end
        if (k == 300) check(0, 1);
        cur_lane = ln;
        cur_addr = a[19:0];
        cur_b = a;
        slow = $random(seed);
        if (wr) begin
            ref_b[a] = d[7:0];
            if (ln[0]) ref_mem[a[19:0]][7:0] = d[7:0];
            if (ln[1]) ref_mem[a[19:0]][15:8] = d[15:8];
        end else begin
            exp_b.push_back(ref_b.exists(a) ? ref_b[a] : 8'h00);
            exp_q.push_back({{8{ln[1]}}, {8{ln[0]}}, ref_mem[a[19:0]] & {{8{ln[1]}}, {8{ln[0]}}}});
            rd_cnt = 0;
        end
        @(negedge clock);
    endtask

    // Pin monitor and read result comparison on pre-edge values
    always @(posedge clock) begin
        if (reset_n) begin
            if (clock_enable && resp_valid) begin
                e = exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFF0000;
                check(rd_cnt, asc_pkg::READ_WAIT + 1);
                check(resp_rdata & e[31:16], e[15:0]);
            end
            if (clock_enable) rd_cnt++;
            if (!chip_select_n) check({chip_select_high_active, upper_lane_select_n, lower_lane_select_n,
                word_address}, {1'b1, ~cur_lane, cur_addr});
            if (host_oe != 16'h0000) check({output_enable_n, host_oe & dev_oe}, {1'b1, 16'h0000});
            if (clock_enable && rv_b) check(rdata_b, {8'h00, exp_b.size() > 0 ? exp_b.pop_front() : 8'hFF});
            if (!cs_n_b) check({lb_n_b, ub_n_b, host_oe_b[15], host_out_b[15], word_address_b, host_oe_b & dev_oe_b},
                {3'b001, cur_b[0], cur_b[20:1], 16'h0000});
        end
    end

    // Reset pin state
    task automatic check_reset;
        check({req_ready, resp_valid, width_strap, chip_select_n, chip_select_high_active, write_strobe_n,
            output_enable_n, host_oe, strap_b}, {7'b1011011, 16'h0000, 1'b0});
    endtask

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    initial begin
        #100000;
        n_fail++;
        test_done();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 17;
        reset_n = 1'b0;
        clock_enable = 1'b1;
        {req_valid, req_write, slow, req_addr, req_wdata, req_lane_en} = '0;
        repeat (4) @(negedge clock);
        check_reset();
        reset_n = 1'b1;
        // Fill the boundary words so every later read has a known value
        for (i = 0; i < 4; i++) do_op(1, {1'b0, tab[i]}, $random(seed), 2'b11);
        // Low-lane, high-lane, then both-lane writes, each read back in full to show an unwritten lane kept
        for (i = 1; i < 4; i++) begin
            do_op(1, {1'b0, tab[i]}, $random(seed), i[1:0]);
            do_op(0, {1'b0, tab[i]}, 16'h0000, 2'b11);
        end
        // Random back-to-back mix; top address bit is ignored in word mode
        repeat (60) begin
            i = $random(seed) & 3;
            do_op($random(seed), {1'($random(seed)), tab[i]}, $random(seed), 2'(1 + ($random(seed) & 1) + (i & 1)));
        end
        // Reset in mid-read, then memory contents must survive
        do_op(0, {1'b0, tab[1]}, 16'h0000, 2'b11);
        repeat (3) @(negedge clock);
        reset_n = 1'b0;
        exp_q.delete();
        exp_b.delete();
        repeat (2) @(negedge clock);
        check_reset();
        reset_n = 1'b1;
        for (i = 0; i < 4; i++) do_op(0, {1'b0, tab[i]}, 16'h0000, 2'b11);
        req_valid = 1'b0;
        for (i = 0; i < 300 && !(req_ready === 1'b1 && rdy_b === 1'b1 && exp_q.size() == 0); i++) @(negedge clock);
        clock_enable = 1'b1;
        check(exp_q.size(), 0);
        check(exp_b.size(), 0);
        test_done();
    end
endmodule
